// *** rtl/hp_seq_pkg.sv ***
// constants, carriers and timing for the heat pump sequencer
package hp_seq_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_MS = 250;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int TICKS_PER_S = 1000 / TICK_MS;
    localparam int TW = 16;
    localparam int SHORT_CYCLE_DELAY_MIN_S = 3;
    localparam int SHORT_CYCLE_DELAY_STEP_MIN = 1;
    localparam logic [3:0] SHORT_CYCLE_DELAY_MAX_SEL = 4'hA;
    localparam logic [3:0] SHORT_CYCLE_DELAY_SEL_DEFAULT = 4'h3;
    localparam int DFR_STEP_MIN = 30;
    localparam logic [1:0] DFR_SEL_DEFAULT = 2'h0;
    localparam int DFR_STEPS_MAX = 3;
    localparam int DFR_MAX_MIN = 10;
    localparam int LPS_BYPASS_MIN = 3;
    localparam logic [TW-1:0] SHORT_CYCLE_DELAY_MIN_TICKS = TW'(SHORT_CYCLE_DELAY_MIN_S * TICKS_PER_S);
    localparam logic [TW-1:0] SHORT_CYCLE_DELAY_STEP_TICKS = TW'(SHORT_CYCLE_DELAY_STEP_MIN * 60 * TICKS_PER_S);
    localparam logic [TW-1:0] DFR_STEP_TICKS = TW'(DFR_STEP_MIN * 60 * TICKS_PER_S);
    localparam logic [TW-1:0] DFR_MAX_TICKS = TW'(DFR_MAX_MIN * 60 * TICKS_PER_S);
    localparam logic [TW-1:0] LPS_BYPASS_TICKS = TW'(LPS_BYPASS_MIN * 60 * TICKS_PER_S);
    localparam logic [7:0] REHEAT_SPEED_DEFAULT = 8'h32;
    localparam logic [7:0] SPEED_RESET = 8'h00;
    localparam logic [1:0] BLINK_RESET = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_COOL = 3'h1,
        ST_HEAT = 3'h2,
        ST_DEHUM = 3'h3,
        ST_DEFROST = 3'h4,
        ST_LOCK = 3'h5
    } mode_t;

    typedef struct packed {
        logic fan_call;
        logic comp_call;
        logic second_stage_call;
        logic changeover_call;
        logic second_heat_call;
    } tstat_t;

    typedef struct packed {
        logic compressor_contactor;
        logic reversing_valve;
        logic indoor_blower_out;
        logic blower_out;
        logic outdoor_fan_out;
        logic heat_contactor;
        logic reheat_solenoid;
        logic second_stage_out;
        logic outdoor_sensor_permit;
        logic lockout_indicator;
    } load_t;

    localparam load_t LOAD_RESET = '0;
endpackage

// *** rtl/hp_sequencer.sv ***
// heat pump and air conditioner sequencing core
//
// Contract
// - fan, compressor, changeover calls: cool, first speed
// - second stage in cooling raises blower speed
// - compressor held off for short-cycle delay
// - cooling run drives compressor, blower, valve, fan
// - heating call drives compressor, valve, full capacity
// - second heat call adds heat contactor
// - outdoor sensor not below set point blocks heat; in defrost the heat contactor ignores the sensor
// - exclusive heat: compressor and fan off, heat on
// - humidity without cooling runs reheat dehumidification
// - cooling call ends dehumidification, reheat off
// - after accumulated interval, defrost thermostat starts defrost
// - defrost: outdoor fan off, reversing valve on
// - defrost ends on thermostat release or ten minutes
// - heat during defrost selection drives heat contactor unless exclusive heat is selected
// - defrost interval accumulates across interruptions
// - defrost test forces defrost, ten minutes or off
// - indicator blinks 1 Hz low, 2 Hz high
// - external shutdown stops the unit
// - short-cycle delay 3 s or 1 to 10 minutes
// - low pressure bypassed 3 min, second trip locks
// - high pressure trips, second trip locks
`timescale 1ns/100ps
`default_nettype none
module hp_sequencer
    import hp_seq_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire tstat_t tstat_i,
    input wire logic high_pressure_switch_open_i,
    input wire logic low_pressure_switch_open_i,
    input wire logic humidity_high_i,
    input wire logic [7:0] supply_temp_i,
    input wire logic [7:0] reheat_on_temp_i,
    input wire logic [7:0] reheat_off_temp_i,
    input wire logic outdoor_sensor_installed_i,
    input wire logic outdoor_below_sp_i,
    input wire logic exclusive_heat_sel_i,
    input wire logic heat_during_defrost_sel_i,
    input wire logic external_shutdown_i,
    input wire logic defrost_thermostat_i,
    input wire logic defrost_test_i,
    input wire logic acc_clear_i,
    input wire logic [3:0] short_cycle_delay_sel_i,
    input wire logic [1:0] defrost_interval_sel_i,
    input wire logic [7:0] first_speed_i,
    input wire logic [7:0] second_speed_i,
    input wire logic [7:0] reheat_speed_i,
    output load_t load_o,
    output logic [7:0] blower_speed_o,
    output mode_t mode_o
);
    function automatic logic [TW-1:0] short_cycle_delay_limit(input logic [3:0] sel);
        logic [TW-1:0] steps;
        steps = (sel > SHORT_CYCLE_DELAY_MAX_SEL) ? TW'(SHORT_CYCLE_DELAY_MAX_SEL) : TW'(sel);
        return (sel == 4'h0) ? SHORT_CYCLE_DELAY_MIN_TICKS : TW'(steps * SHORT_CYCLE_DELAY_STEP_TICKS);
    endfunction

    function automatic logic [TW-1:0] dfr_limit(input logic [1:0] sel);
        logic [TW-1:0] n;
        n = (sel == 2'h3) ? TW'(DFR_STEPS_MAX) : TW'(sel) + 1'b1;
        return TW'(n * DFR_STEP_TICKS);
    endfunction

    function automatic mode_t base_mode(input logic cool, input logic heat, input logic dehum);
        if (cool)
            return ST_COOL;
        else if (heat)
            return ST_HEAT;
        else if (dehum)
            return ST_DEHUM;
        else
            return ST_IDLE;
    endfunction

    mode_t mode_ff, nxt_mode;
    load_t load_ff, nxt_load;
    logic [7:0] speed_ff, nxt_speed;
    logic comp_run_ff, nxt_comp;
    logic lp_hold_ff, hp_hold_ff, lp_strike_ff, hp_strike_ff, lock_hp_ff;
    logic test_ff, test_run_ff, rh_ff;
    logic [1:0] blink_ff;
    logic [TW-1:0] acc_ff;
    logic tick, short_cycle_delay_done, bypass_done, dur_done;
    logic cool_call, heat_call, dehum_call, any_call, heat_permit;
    logic excl_block, lp_trip, hp_trip, lock_trip, test_rise, dfr_due;
    logic dfr_enter, dfr_exit, lp_ind, hp_ind;

    tick_gen #(.DIV(TICK_DIV)) u_tick (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .tick_o(tick)
    );

    // delay restarts whenever the compressor drops, and at reset
    interval_timer #(.W(TW)) u_short_cycle_delay (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .clear_i(comp_run_ff && !nxt_comp),
        .run_i(!comp_run_ff),
        .tick_i(tick),
        .limit_i(short_cycle_delay_limit(short_cycle_delay_sel_i)),
        .done_o(short_cycle_delay_done)
    );

    interval_timer #(.W(TW)) u_bypass (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .clear_i(!comp_run_ff),
        .run_i(comp_run_ff),
        .tick_i(tick),
        .limit_i(LPS_BYPASS_TICKS),
        .done_o(bypass_done)
    );

    interval_timer #(.W(TW)) u_dur (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .clear_i(mode_ff != ST_DEFROST),
        .run_i(1'b1),
        .tick_i(tick),
        .limit_i(DFR_MAX_TICKS),
        .done_o(dur_done)
    );

    assign cool_call = tstat_i.fan_call && tstat_i.comp_call && tstat_i.changeover_call;
    assign heat_call = tstat_i.fan_call && tstat_i.comp_call
                       && tstat_i.second_stage_call && !tstat_i.changeover_call;
    assign dehum_call = !cool_call && !heat_call && humidity_high_i;
    assign any_call = cool_call || heat_call || dehum_call;
    assign heat_permit = !outdoor_sensor_installed_i || outdoor_below_sp_i;
    assign excl_block = exclusive_heat_sel_i && tstat_i.second_heat_call && heat_permit;

    assign lp_trip = comp_run_ff && bypass_done && low_pressure_switch_open_i;
    assign hp_trip = comp_run_ff && high_pressure_switch_open_i;
    assign lock_trip = (lp_trip && !lp_hold_ff && lp_strike_ff)
                       || (hp_trip && !hp_hold_ff && hp_strike_ff);

    assign test_rise = defrost_test_i && !test_ff;
    assign dfr_due = (acc_ff >= dfr_limit(defrost_interval_sel_i));
    assign dfr_enter = (mode_ff == ST_HEAT) && comp_run_ff
                       && ((dfr_due && defrost_thermostat_i) || test_rise);
    assign dfr_exit = dur_done
                      || (test_run_ff ? !defrost_test_i : !defrost_thermostat_i);

    always_comb
    begin
        nxt_mode = mode_ff;
        if (external_shutdown_i)
            nxt_mode = ST_IDLE;
        else if (lock_trip)
            nxt_mode = ST_LOCK;
        else
        begin
            unique case (mode_ff)
                ST_IDLE, ST_COOL, ST_DEHUM:
                    nxt_mode = base_mode(cool_call, heat_call, dehum_call);
                ST_HEAT:
                    nxt_mode = dfr_enter ? ST_DEFROST : base_mode(cool_call, heat_call, dehum_call);
                ST_DEFROST:
                    if (!heat_call)
                        nxt_mode = base_mode(cool_call, heat_call, dehum_call);
                    else if (dfr_exit)
                        nxt_mode = ST_HEAT;
                ST_LOCK:
                    if (!any_call)
                        nxt_mode = ST_IDLE;
                default:
                    nxt_mode = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            mode_ff <= ST_IDLE;
        else
            mode_ff <= nxt_mode;
    end

    // compressor may start only once the short-cycle delay has run out
    always_comb
    begin
        nxt_comp = 1'b0;
        if (!external_shutdown_i && !lp_hold_ff && !hp_hold_ff && !lock_trip
            && !lp_trip && !hp_trip)
        begin
            unique case (mode_ff)
                ST_COOL, ST_DEHUM, ST_DEFROST:
                    nxt_comp = comp_run_ff || short_cycle_delay_done;
                ST_HEAT:
                    nxt_comp = !excl_block && (comp_run_ff || short_cycle_delay_done);
                default:
                    nxt_comp = 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            comp_run_ff <= 1'b0;
        else
            comp_run_ff <= nxt_comp;
    end

    // a trip holds the compressor off until the switch closes again
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            lp_hold_ff <= 1'b0;
            hp_hold_ff <= 1'b0;
        end
        else
        begin
            lp_hold_ff <= lp_trip || (lp_hold_ff && low_pressure_switch_open_i);
            hp_hold_ff <= hp_trip || (hp_hold_ff && high_pressure_switch_open_i);
        end
    end

    // strikes count per call; a new trip wins over the end of the call
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            lp_strike_ff <= 1'b0;
            hp_strike_ff <= 1'b0;
        end
        else
        begin
            lp_strike_ff <= (lp_trip && !lp_hold_ff) || (lp_strike_ff && any_call);
            hp_strike_ff <= (hp_trip && !hp_hold_ff) || (hp_strike_ff && any_call);
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            lock_hp_ff <= 1'b0;
        else if (lock_trip)
            lock_hp_ff <= hp_trip && !hp_hold_ff && hp_strike_ff;
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            test_ff <= 1'b0;
            test_run_ff <= 1'b0;
        end
        else
        begin
            test_ff <= defrost_test_i;
            if (mode_ff != ST_DEFROST && nxt_mode != ST_DEFROST)
                test_run_ff <= 1'b0;
            else if (dfr_enter && test_rise)
                test_run_ff <= 1'b1;
        end
    end

    // kept through reset on purpose; only acc_clear_i or a defrost zeroes it
    always_ff @(posedge mclk_i)
    begin
        if (acc_clear_i || (dfr_enter && !reset_i))
            acc_ff <= '0;
        else if (!reset_i && tick && mode_ff == ST_HEAT && comp_run_ff && !dfr_due)
            acc_ff <= acc_ff + 1'b1;
    end

    // reheat hysteresis on supply air temperature
    always_ff @(posedge mclk_i)
    begin
        if (reset_i || cool_call || mode_ff != ST_DEHUM)
            rh_ff <= 1'b0;
        else if (supply_temp_i <= reheat_on_temp_i)
            rh_ff <= 1'b1;
        else if (supply_temp_i >= reheat_off_temp_i)
            rh_ff <= 1'b0;
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            blink_ff <= BLINK_RESET;
        else if (tick)
            blink_ff <= blink_ff + 1'b1;
    end

    assign lp_ind = lp_hold_ff || (mode_ff == ST_LOCK && !lock_hp_ff);
    assign hp_ind = hp_hold_ff || (mode_ff == ST_LOCK && lock_hp_ff);

    always_comb
    begin
        nxt_load = LOAD_RESET;
        nxt_speed = SPEED_RESET;
        unique case (mode_ff)
            ST_COOL:
            begin
                nxt_load.compressor_contactor = comp_run_ff;
                nxt_load.reversing_valve = 1'b1;
                nxt_load.outdoor_fan_out = comp_run_ff;
                nxt_load.second_stage_out = comp_run_ff && tstat_i.second_stage_call;
                nxt_speed = tstat_i.second_stage_call ? second_speed_i : first_speed_i;
            end
            ST_HEAT:
            begin
                nxt_load.compressor_contactor = comp_run_ff && !excl_block;
                nxt_load.reversing_valve = 1'b1;
                nxt_load.second_stage_out = comp_run_ff && !excl_block;
                nxt_load.outdoor_fan_out = comp_run_ff && !excl_block;
                nxt_load.heat_contactor = tstat_i.second_heat_call && heat_permit;
                nxt_speed = second_speed_i;
            end
            ST_DEHUM:
            begin
                nxt_load.compressor_contactor = comp_run_ff;
                nxt_load.second_stage_out = comp_run_ff;
                nxt_load.reversing_valve = 1'b1;
                nxt_load.outdoor_fan_out = comp_run_ff;
                nxt_load.reheat_solenoid = rh_ff && !cool_call;
                nxt_speed = reheat_speed_i;
            end
            ST_DEFROST:
            begin
                nxt_load.compressor_contactor = comp_run_ff;
                nxt_load.second_stage_out = comp_run_ff;
                nxt_load.reversing_valve = 1'b1;
                nxt_load.outdoor_fan_out = 1'b0;
                nxt_load.heat_contactor = heat_during_defrost_sel_i && !exclusive_heat_sel_i;
                nxt_speed = second_speed_i;
            end
            default:
                nxt_speed = tstat_i.fan_call ? first_speed_i : SPEED_RESET;
        endcase
        nxt_load.indoor_blower_out = tstat_i.fan_call || (mode_ff == ST_DEHUM);
        nxt_load.blower_out = nxt_load.indoor_blower_out;
        nxt_load.outdoor_sensor_permit = heat_permit;
        nxt_load.lockout_indicator = hp_ind ? blink_ff[0] : (lp_ind && blink_ff[1]);
        if (external_shutdown_i)
        begin
            nxt_load = LOAD_RESET;
            nxt_speed = SPEED_RESET;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            load_ff <= LOAD_RESET;
            speed_ff <= SPEED_RESET;
        end
        else
        begin
            load_ff <= nxt_load;
            speed_ff <= nxt_speed;
        end
    end

    assign load_o = load_ff;
    assign blower_speed_o = speed_ff;
    assign mode_o = mode_ff;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);

    sequence in_defrost;
        mode_ff == ST_DEFROST && !external_shutdown_i;
    endsequence

    shutdown_off_a: assert property (
        external_shutdown_i |=> load_ff == LOAD_RESET && speed_ff == SPEED_RESET)
        else $error("outputs active after external shutdown");
    short_cycle_a: assert property (
        $rose(comp_run_ff) |-> $past(short_cycle_delay_done))
        else $error("compressor started inside short-cycle delay");
    cool_outputs_a: assert property (
        mode_ff == ST_COOL && comp_run_ff && !external_shutdown_i |=>
        load_ff.compressor_contactor && load_ff.reversing_valve && load_ff.outdoor_fan_out)
        else $error("cooling outputs missing");
    exclusive_heat_a: assert property (
        load_ff.heat_contactor && $past(exclusive_heat_sel_i) |->
        !load_ff.compressor_contactor && !load_ff.outdoor_fan_out)
        else $error("heat and compressor together under exclusive heat");
    outdoor_block_a: assert property (
        $past(outdoor_sensor_installed_i && !outdoor_below_sp_i && mode_ff != ST_DEFROST)
        |-> !load_ff.heat_contactor)
        else $error("heat on while outdoor sensor forbids it");
    defrost_fan_a: assert property (
        in_defrost |=> !load_ff.outdoor_fan_out && load_ff.reversing_valve)
        else $error("defrost outputs wrong");
    defrost_limit_a: assert property (
        mode_ff == ST_DEFROST && dur_done |=> mode_ff != ST_DEFROST)
        else $error("defrost outlasted its limit");
    reheat_preempt_a: assert property (
        cool_call |=> !load_ff.reheat_solenoid)
        else $error("reheat on during a cooling call");
    lockout_stop_a: assert property (
        mode_ff == ST_LOCK ##1 mode_ff == ST_LOCK |-> !load_ff.compressor_contactor)
        else $error("compressor on in lockout");
endmodule
`default_nettype wire

// *** rtl/interval_timer.sv ***
// saturating tick counter with a level that marks the interval elapsed
`timescale 1ns/100ps
`default_nettype none
module interval_timer #(
    parameter int W = 16
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic clear_i,
    input wire logic run_i,
    input wire logic tick_i,
    input wire logic [W-1:0] limit_i,
    output logic done_o
);
    logic [W-1:0] count_ff;

    always_ff @(posedge mclk_i)
    begin
        if (reset_i || clear_i)
            count_ff <= '0;
        else if (run_i && tick_i && !done_o)
            count_ff <= count_ff + 1'b1;
    end

    assign done_o = (count_ff >= limit_i);
endmodule
`default_nettype wire

// *** rtl/tick_gen.sv ***
// prescaler that gives one tick pulse every DIV clocks
`timescale 1ns/100ps
`default_nettype none
module tick_gen #(
    parameter int DIV = 10
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    output logic tick_o
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    logic [CW-1:0] cnt_ff;

    always_ff @(posedge mclk_i)
    begin
        if (reset_i || cnt_ff == LAST)
            cnt_ff <= '0;
        else
            cnt_ff <= cnt_ff + 1'b1;
    end

    assign tick_o = (cnt_ff == LAST);
endmodule
`default_nettype wire

// *** verification/hp_plant.sv ***
// far-side model: outdoor coil thermostat and refrigerant switches
`timescale 1ns/100ps
`default_nettype none
module hp_plant
    import hp_seq_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire load_t load_i,
    input wire logic cold_i,
    input wire logic [15:0] warm_i,
    input wire logic lp_i,
    input wire logic hp_i,
    output logic dfc_o,
    output logic lp_o,
    output logic hp_o
);
    logic [15:0] heat_ff;
    // coil warms only while running reversed with the fan stopped
    always_ff @(posedge mclk_i)
    begin
        if (reset_i || !cold_i)
            heat_ff <= 16'h0000;
        else if (load_i.reversing_valve && !load_i.outdoor_fan_out && load_i.compressor_contactor)
            heat_ff <= heat_ff + 16'h0001;
    end
    assign dfc_o = cold_i && (heat_ff < warm_i);
    // lost charge keeps the low side open until repaired
    assign lp_o = lp_i;
    assign hp_o = hp_i;
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the heat pump sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import hp_seq_pkg::*;
    localparam int TK = 4;
    localparam logic [4:0] C_COOL = 5'h1A;
    localparam logic [4:0] C_COOL2 = 5'h1E;
    localparam logic [4:0] C_HEAT = 5'h1C;
    localparam logic [4:0] C_HEAT2 = 5'h1D;
    localparam logic [11:0] CS = 12'hFA0;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    tstat_t tstat = '0;
    logic hum = 1'b0;
    logic inst = 1'b0;
    logic below = 1'b0;
    logic excl = 1'b0;
    logic shut = 1'b0;
    logic dtest = 1'b0;
    logic hdd = 1'b1;
    logic [3:0] asel = 4'h0;
    logic acc_clr = 1'b1;
    logic cold = 1'b0;
    logic lp_f = 1'b0;
    logic hp_f = 1'b0;
    logic [7:0] supply = 8'h80;
    logic [7:0] on_t = 8'h40;
    logic [7:0] off_t = 8'h60;
    logic [7:0] sp1 = 8'h20;
    logic [7:0] sp2 = 8'h40;
    logic [7:0] sp_rh = 8'h32;
    logic dfc;
    logic lp_open;
    logic hp_open;
    load_t load_o;
    logic [7:0] blower_speed_o;
    mode_t mode_o;
    int failures = 0;
    int num_checks = 0;
    int cyc_cnt = 0;
    int g;
    int k;

    hp_sequencer #(.TICK_DIV(TK)) dut (.mclk_i(mclk_i), .reset_i(reset_i), .tstat_i(tstat),
        .high_pressure_switch_open_i(hp_open), .low_pressure_switch_open_i(lp_open),
        .humidity_high_i(hum), .supply_temp_i(supply), .reheat_on_temp_i(on_t),
        .reheat_off_temp_i(off_t), .outdoor_sensor_installed_i(inst),
        .outdoor_below_sp_i(below), .exclusive_heat_sel_i(excl),
        .heat_during_defrost_sel_i(hdd), .external_shutdown_i(shut),
        .defrost_thermostat_i(dfc), .defrost_test_i(dtest), .acc_clear_i(acc_clr),
        .short_cycle_delay_sel_i(asel), .defrost_interval_sel_i(2'h0),
        .first_speed_i(sp1), .second_speed_i(sp2), .reheat_speed_i(sp_rh),
        .load_o(load_o), .blower_speed_o(blower_speed_o), .mode_o(mode_o));

    hp_plant plant (.mclk_i(mclk_i), .reset_i(reset_i), .load_i(load_o), .cold_i(cold),
        .warm_i(16'h0190), .lp_i(lp_f), .hp_i(hp_f), .dfc_o(dfc), .lp_o(lp_open),
        .hp_o(hp_open));

    always #12.5 mclk_i = ~mclk_i;

    task automatic results();
        if (failures == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge mclk_i)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 90000)
        begin
            failures = failures + 1;
            results();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask

    task automatic set_t(input logic [4:0] v);
        @(posedge mclk_i);
        tstat <= tstat_t'(v);
    endtask

    task automatic wait_cc(input logic v, input int lim);
        g = 0;
        while (load_o.compressor_contactor !== v && g < lim)
        begin
            @(negedge mclk_i);
            g++;
        end
        chk(16'(load_o.compressor_contactor), 16'(v));
    endtask

    task automatic wait_md(input mode_t m, input int lim);
        g = 0;
        while (mode_o !== m && g < lim)
        begin
            @(negedge mclk_i);
            g++;
        end
        chk(16'(mode_o), 16'(m));
    endtask

    // half period of the lockout blink, in clocks
    task automatic blink_gap(input int exp);
        logic l;
        int n;
        for (int i = 0; i < 2; i++)
        begin
            l = load_o.lockout_indicator;
            n = 0;
            while (load_o.lockout_indicator === l && n < 100)
            begin
                @(negedge mclk_i);
                n++;
            end
        end
        chk(16'(n), 16'(exp));
    endtask

    // {heat, compressor, fan, permit} for case {installed, below, exclusive}
    function automatic logic [3:0] exp_ht(input logic [2:0] c);
        logic p;
        p = !c[2] || c[1];
        return {p, !(c[0] && p), !(c[0] && p), p};
    endfunction

    initial
    begin
        void'($urandom(32'hDCB6DA31));
        repeat (8) @(posedge mclk_i);
        reset_i <= 1'b0;
        acc_clr <= 1'b0;
        tstat <= tstat_t'(C_COOL);
        sp1 <= 8'($urandom_range(16, 64));
        sp2 <= 8'($urandom_range(65, 200));
        sp_rh <= 8'($urandom_range(20, 90));
        g = $urandom_range(32, 96);
        on_t <= 8'(g);
        off_t <= 8'(g + 16);
        k = cyc_cnt;
        cyc(20);
        chk(16'(load_o.compressor_contactor), 16'h0000);
        wait_cc(1'b1, 300);
        chk(16'(cyc_cnt - k >= 12 * TK - 1), 16'h0001);
        chk(16'(mode_o), 16'(ST_COOL));
        chk(16'({load_o.reversing_valve, load_o.outdoor_fan_out, load_o.indoor_blower_out,
            load_o.blower_out}), 16'h000F);
        chk(16'(blower_speed_o), 16'(sp1));
        for (k = 0; k < 6; k++)
        begin
            g = $urandom_range(0, 1);
            set_t(g ? C_COOL2 : C_COOL);
            cyc(4);
            chk(16'(blower_speed_o), 16'(g ? sp2 : sp1));
        end
        @(posedge mclk_i);
        tstat <= '0;
        hum <= 1'b1;
        supply <= on_t - 8'h01;
        wait_md(ST_DEHUM, 5);
        wait_cc(1'b1, 300);
        cyc(4);
        chk(16'({load_o.reheat_solenoid, load_o.second_stage_out}), 16'h0003);
        chk(16'(blower_speed_o), 16'(sp_rh));
        @(posedge mclk_i);
        supply <= off_t;
        cyc(4);
        chk(16'(load_o.reheat_solenoid), 16'h0000);
        @(posedge mclk_i);
        supply <= on_t;
        cyc(4);
        chk(16'(load_o.reheat_solenoid), 16'h0001);
        set_t(C_COOL);
        cyc(4);
        chk(16'({mode_o, load_o.reheat_solenoid}), 16'({ST_COOL, 1'b0}));
        @(posedge mclk_i);
        hum <= 1'b0;
        tstat <= tstat_t'(C_HEAT);
        wait_md(ST_HEAT, 5);
        wait_cc(1'b1, 300);
        cyc(2);
        chk(16'({load_o.reversing_valve, load_o.second_stage_out}), 16'h0003);
        chk(16'(blower_speed_o), 16'(sp2));
        for (k = 0; k < 4; k++)
        begin
            @(posedge mclk_i);
            tstat <= tstat_t'(C_HEAT2);
            {inst, below, excl} <= 3'(CS >> (3 * k));
            cyc(4);
            chk(16'({load_o.heat_contactor, load_o.compressor_contactor, load_o.outdoor_fan_out,
                load_o.outdoor_sensor_permit}), 16'(exp_ht(3'(CS >> (3 * k)))));
        end
        @(posedge mclk_i);
        tstat <= tstat_t'(C_HEAT);
        {inst, below, excl} <= 3'h0;
        wait_cc(1'b1, 300);
        @(posedge mclk_i);
        dtest <= 1'b1;
        wait_md(ST_DEFROST, 5);
        cyc(2);
        chk(16'({load_o.outdoor_fan_out, load_o.reversing_valve, load_o.heat_contactor}),
            16'h0003);
        wait_md(ST_HEAT, 9700);
        chk(16'(g >= 2400 * TK - 8), 16'h0001);
        @(posedge mclk_i);
        dtest <= 1'b0;
        hdd <= 1'b0;
        cyc(4);
        @(posedge mclk_i);
        dtest <= 1'b1;
        wait_md(ST_DEFROST, 5);
        cyc(10);
        chk(16'(load_o.heat_contactor), 16'h0000);
        @(posedge mclk_i);
        dtest <= 1'b0;
        hdd <= 1'b1;
        wait_md(ST_HEAT, 5);
        @(posedge mclk_i);
        cold <= 1'b1;
        cyc(16000);
        chk(16'(mode_o), 16'(ST_HEAT));
        set_t(5'h00);
        cyc(100);
        set_t(C_HEAT);
        wait_md(ST_DEFROST, 14000);
        wait_md(ST_HEAT, 600);
        chk(16'(g >= 400), 16'h0001);
        @(posedge mclk_i);
        cold <= 1'b0;
        lp_f <= 1'b1;
        wait_cc(1'b0, 3);
        blink_gap(2 * TK);
        @(posedge mclk_i);
        lp_f <= 1'b0;
        wait_cc(1'b1, 300);
        cyc(40);
        @(posedge mclk_i);
        lp_f <= 1'b1;
        cyc(20);
        chk(16'(load_o.compressor_contactor), 16'h0001);
        @(posedge mclk_i);
        lp_f <= 1'b0;
        cyc(720 * TK);
        @(posedge mclk_i);
        lp_f <= 1'b1;
        wait_md(ST_LOCK, 5);
        blink_gap(2 * TK);
        @(posedge mclk_i);
        lp_f <= 1'b0;
        tstat <= '0;
        wait_md(ST_IDLE, 5);
        set_t(C_COOL);
        wait_cc(1'b1, 300);
        @(posedge mclk_i);
        hp_f <= 1'b1;
        wait_cc(1'b0, 3);
        blink_gap(TK);
        @(posedge mclk_i);
        hp_f <= 1'b0;
        asel <= 4'h1;
        k = cyc_cnt;
        wait_cc(1'b1, 1100);
        chk(16'(cyc_cnt - k >= 232 * TK), 16'h0001);
        @(posedge mclk_i);
        hp_f <= 1'b1;
        asel <= 4'h0;
        wait_md(ST_LOCK, 5);
        @(posedge mclk_i);
        hp_f <= 1'b0;
        tstat <= '0;
        wait_md(ST_IDLE, 5);
        set_t(C_COOL);
        wait_cc(1'b1, 300);
        @(posedge mclk_i);
        shut <= 1'b1;
        cyc(3);
        chk(16'(load_o), 16'(LOAD_RESET));
        results();
    end
endmodule
`default_nettype wire
